// file: bench/touch_host_model.sv
// Host side model that drives the internal register byte port.
module touch_host_model (
    input  wire logic       clock,
    output logic [7:0]      reg_addr,
    output logic            reg_write,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_addr  = 8'h00;
        reg_write = 1'b0;
        reg_wdata = 8'h00;
    end

    // Released data is inverted so a stale byte never looks valid.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        repeat (2) @(posedge clock);
        #1;
        d = reg_rdata_ff;
    endtask : read_reg
endmodule : touch_host_model

// file: bench/touch_recal_regs_bench.sv
// Self-checking bench for the recalibration and interrupt enable registers.
module touch_recal_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock, reset, reg_write, slide_active, irq_ff;
    logic        slide_repeat_ff;
    logic [7:0]  reg_addr, reg_wdata, gpio_change_status, reg_rdata_ff;
    logic [13:0] sample_enable, sense_touch, recal_busy_ff;
    logic [13:0] analog_update_ff, base_capture_ff;
    logic [6:0]  auto_recal_request, touch_status;
    logic [3:0]  group_event_status;
    int          fails = 0;
    int          n_tests = 0;
    int          n;

    // Short counts keep the run small; expectations derive from them.
    touch_recal_regs #(.MS_CYCLES(10), .ANALOG_CYCLES(20),
        .DIGITAL_CYCLES(20)) u_dut (.clock, .reset, .reg_addr, .reg_write,
        .reg_wdata, .sample_enable, .sense_touch, .auto_recal_request,
        .touch_status, .group_event_status, .gpio_change_status,
        .slide_active, .reg_rdata_ff, .irq_ff, .recal_busy_ff,
        .analog_update_ff, .base_capture_ff, .slide_repeat_ff);
    touch_host_model u_host (.clock, .reg_addr, .reg_write, .reg_wdata,
        .reg_rdata_ff);

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(a, d);
        check(d, exp);
    endtask : rd_check

    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask : settle

    // Kind 0 waits for busy, 1 for a base capture, 2 for a slide repeat.
    task automatic wait_for(input int kind, input int ch, input int limit);
        logic hit;
        n = 0;
        hit = 1'b0;
        while (hit !== 1'b1)
        begin
            @(posedge clock);
            #1;
            n++;
            hit = kind == 0 ? recal_busy_ff[ch] :
                  kind == 1 ? base_capture_ff[ch] : slide_repeat_ff;
            if (n > limit)
            begin
                fails++;
                $display("[ERR] %0t wait ran out", $time);
                report_and_stop();
            end
        end
    endtask : wait_for

    task automatic pulse_auto(input int ch);
        @(posedge clock);
        auto_recal_request[ch] <= 1'b1;
        @(posedge clock);
        auto_recal_request[ch] <= 1'b0;
    endtask : pulse_auto

    // A start anywhere in the window fails, not only one still running.
    task automatic quiet(input int ch, input int cycles);
        logic seen;
        seen = 1'b0;
        repeat (cycles)
        begin
            @(posedge clock);
            #1;
            seen = seen | recal_busy_ff[ch];
        end
        check(seen, 1'b0);
    endtask : quiet

    task automatic t_reset;
        rd_check(8'h24, 8'hD4);
        rd_check(8'h25, 8'hFF);
        rd_check(8'h26, 8'h00);
        rd_check(8'h27, 8'hFF);
        rd_check(8'h28, 8'h00);
        rd_check(8'h46, 8'h00);
        rd_check(8'h30, 8'h00);
        u_host.write_reg(8'h46, 8'h80);
        rd_check(8'h46, 8'h00);
    endtask : t_reset

    task automatic t_manual;
        u_host.write_reg(8'h26, 8'h01);
        wait_for(0, 0, 10);
        check(analog_update_ff[0], 1'b1);
        wait_for(1, 0, 60);
        check(n, 40);
        check(analog_update_ff[0], 1'b0);
        rd_check(8'h26, 8'h00);
    endtask : t_manual

    task automatic t_abort;
        logic seen;
        seen = 1'b0;
        u_host.write_reg(8'h46, 8'h01);
        wait_for(0, 7, 10);
        repeat (30) @(posedge clock);
        sense_touch[7] <= 1'b1;
        repeat (15)
        begin
            @(posedge clock);
            #1;
            seen = seen | base_capture_ff[7];
        end
        check(seen, 1'b0);
        rd_check(8'h46, 8'h01);
        wait_for(1, 7, 60);
        @(posedge clock);
        sense_touch[7] <= 1'b0;
        rd_check(8'h46, 8'h00);
    endtask : t_abort

    task automatic t_group;
        u_host.write_reg(8'h26, 8'h80);
        wait_for(0, 13, 10);
        check(recal_busy_ff[13:7], 7'h7F);
        wait_for(1, 13, 60);
        rd_check(8'h26, 8'h00);
    endtask : t_group

    task automatic t_auto;
        @(posedge clock);
        sample_enable[1] <= 1'b0;
        pulse_auto(1);
        settle();
        check(recal_busy_ff[1], 1'b0);
        u_host.write_reg(8'h25, 8'hFD);
        sample_enable[1] <= 1'b1;
        pulse_auto(1);
        settle();
        check(recal_busy_ff[1], 1'b0);
        u_host.write_reg(8'h25, 8'hFF);
        pulse_auto(1);
        wait_for(0, 1, 5);
        wait_for(1, 1, 60);
    endtask : t_auto

    // A 560 ms limit is the shortest code, so the wait stays affordable.
    task automatic t_press_limit;
        u_host.write_reg(8'h24, 8'h00);
        sense_touch[8] <= 1'b1;
        rd_check(8'h24, 8'h00);
        quiet(8, 5500);
        wait_for(0, 8, 200);
        @(posedge clock);
        sense_touch[8] <= 1'b0;
        wait_for(1, 8, 60);
        u_host.write_reg(8'h25, 8'h7F);
        sense_touch[8] <= 1'b1;
        quiet(8, 5800);
        @(posedge clock);
        sense_touch[8] <= 1'b0;
        u_host.write_reg(8'h25, 8'hFF);
        @(posedge clock);
        slide_active <= 1'b1;
        wait_for(2, 0, 400);
        wait_for(2, 0, 400);
        check(n, 350);
        @(posedge clock);
        slide_active <= 1'b0;
    endtask : t_press_limit

    task automatic t_irq;
        @(posedge clock);
        touch_status[0] <= 1'b1;
        settle();
        check(irq_ff, 1'b1);
        u_host.write_reg(8'h27, 8'hFE);
        settle();
        check(irq_ff, 1'b0);
        @(posedge clock);
        touch_status[0] <= 1'b0;
        gpio_change_status[7] <= 1'b1;
        settle();
        check(irq_ff, 1'b0);
        u_host.write_reg(8'h28, 8'h80);
        settle();
        check(irq_ff, 1'b1);
        @(posedge clock);
        gpio_change_status[7] <= 1'b0;
        group_event_status <= 4'h8;
        settle();
        check(irq_ff, 1'b1);
        u_host.write_reg(8'h27, 8'h7F);
        settle();
        check(irq_ff, 1'b0);
    endtask : t_irq

    initial
    begin
        reset = 1'b1;
        sample_enable = 14'h3FFF;
        sense_touch = 14'h0000;
        auto_recal_request = 7'h00;
        touch_status = 7'h00;
        group_event_status = 4'h0;
        gpio_change_status = 8'h00;
        slide_active = 1'b0;
        repeat (3) @(posedge clock);
        reset <= 1'b0;
        t_reset();
        t_manual();
        t_abort();
        t_group();
        t_auto();
        t_press_limit();
        t_irq();
        report_and_stop();
    end
endmodule : touch_recal_regs_bench

// file: hw/recal_engine.sv
// One sensor's recalibration sequencer: analog update, then base capture.
module recal_engine #(
    parameter int ANALOG_CYCLES  = 30_000_000,
    parameter int DIGITAL_CYCLES = 30_000_000
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic start,
    input  wire logic touch,
    output logic      busy_ff,
    output logic      analog_ff,
    output logic      capture_ff,
    output logic      done_ff
);

    touch_recal_pkg::recal_state_type state_ff;
    touch_recal_pkg::recal_state_type nxt_state;
    logic [31:0] cnt_ff;
    logic [31:0] nxt_cnt;
    logic        touch_prev_ff;
    logic        nxt_capture;
    logic        nxt_done;
    logic        press;

    // A held finger must not stall a forced recalibration, so only a new
    // press counts against the attempt.
    assign press = touch & ~touch_prev_ff;

    always_comb
    begin
        nxt_state   = state_ff;
        nxt_cnt     = cnt_ff;
        nxt_capture = 1'b0;
        nxt_done    = 1'b0;
        case (state_ff)
            touch_recal_pkg::RECAL_IDLE:
            begin
                if (start)
                begin
                    nxt_state = touch_recal_pkg::RECAL_ANALOG;
                    nxt_cnt   = 32'h0000_0000;
                end
            end
            touch_recal_pkg::RECAL_ANALOG:
            begin
                if (press)
                    nxt_state = touch_recal_pkg::RECAL_IDLE;
                else if (cnt_ff == 32'(ANALOG_CYCLES - 1))
                begin
                    nxt_state = touch_recal_pkg::RECAL_DIGITAL;
                    nxt_cnt   = 32'h0000_0000;
                end
                else
                    nxt_cnt = cnt_ff + 32'h0000_0001;
            end
            touch_recal_pkg::RECAL_DIGITAL:
            begin
                if (press)
                    nxt_state = touch_recal_pkg::RECAL_IDLE;
                else if (cnt_ff == 32'(DIGITAL_CYCLES - 1))
                begin
                    nxt_state   = touch_recal_pkg::RECAL_IDLE;
                    nxt_capture = 1'b1;
                    nxt_done    = 1'b1;
                end
                else
                    nxt_cnt = cnt_ff + 32'h0000_0001;
            end
            default: nxt_state = touch_recal_pkg::RECAL_IDLE;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_ff      <= touch_recal_pkg::RECAL_IDLE;
            cnt_ff        <= 32'h0000_0000;
            touch_prev_ff <= 1'b0;
            busy_ff       <= 1'b0;
            analog_ff     <= 1'b0;
            capture_ff    <= 1'b0;
            done_ff       <= 1'b0;
        end
        else
        begin
            state_ff      <= nxt_state;
            cnt_ff        <= nxt_cnt;
            touch_prev_ff <= touch;
            busy_ff       <= nxt_state != touch_recal_pkg::RECAL_IDLE;
            analog_ff     <= nxt_state == touch_recal_pkg::RECAL_ANALOG;
            capture_ff    <= nxt_capture;
            done_ff       <= nxt_done;
        end
    end

    property p_press_aborts;
        @(posedge clock) disable iff (reset)
        (state_ff != touch_recal_pkg::RECAL_IDLE && press)
            |=> (!done_ff && state_ff == touch_recal_pkg::RECAL_IDLE);
    endproperty
    a_press_aborts: assert property (p_press_aborts)
        else $error("Recalibration not abandoned on a new press.");

    sequence s_digital_end;
        state_ff == touch_recal_pkg::RECAL_DIGITAL
            && cnt_ff == 32'(DIGITAL_CYCLES - 1) && !press;
    endsequence
    property p_capture_after_digital;
        @(posedge clock) disable iff (reset)
        s_digital_end |=> (capture_ff && done_ff && !busy_ff);
    endproperty
    a_capture_after_digital: assert property (p_capture_after_digital)
        else $error("Base capture missing at end of digital phase.");

    property p_done_only_from_digital;
        @(posedge clock) disable iff (reset)
        done_ff |-> $past(state_ff) == touch_recal_pkg::RECAL_DIGITAL;
    endproperty
    a_done_only_from_digital: assert property (p_done_only_from_digital)
        else $error("Recalibration finished without a digital phase.");

    property p_busy_bounded;
        @(posedge clock) disable iff (reset)
        cnt_ff < 32'(ANALOG_CYCLES + DIGITAL_CYCLES);
    endproperty
    a_busy_bounded: assert property (p_busy_bounded)
        else $error("Recalibration phase ran past its limit.");

endmodule : recal_engine

// file: hw/touch_recal_pkg.sv
// Package with register map, reset values, field positions and timing.
package touch_recal_pkg;

    localparam logic [7:0] ADDR_GROUP_TIMING  = 8'h24;
    localparam logic [7:0] ADDR_AUTO_RECAL    = 8'h25;
    localparam logic [7:0] ADDR_TRIG_LOW      = 8'h26;
    localparam logic [7:0] ADDR_TOUCH_IRQ     = 8'h27;
    localparam logic [7:0] ADDR_GPIO_IRQ      = 8'h28;
    localparam logic [7:0] ADDR_TRIG_GROUPED  = 8'h46;

    localparam logic [7:0] RST_GROUP_TIMING   = 8'hD4;
    localparam logic [7:0] RST_AUTO_RECAL     = 8'hFF;
    localparam logic [7:0] RST_TRIG_LOW       = 8'h00;
    localparam logic [7:0] RST_TOUCH_IRQ      = 8'hFF;
    localparam logic [7:0] RST_GPIO_IRQ       = 8'h00;
    localparam logic [6:0] RST_TRIG_GROUPED   = 7'h00;

    localparam int MAX_PRESS_LSB  = 4;
    localparam int SLIDE_RPT_LSB  = 0;
    localparam int GROUP_BIT      = 7;
    localparam int LOW_CHANNELS   = 7;
    localparam int GROUP_CHANNELS = 7;

    localparam int CLOCK_HZ         = 100_000_000;
    localparam int MS_PER_TICK      = 1;
    localparam int MS_TICK_CYCLES   = CLOCK_HZ / 1000 * MS_PER_TICK;
    localparam int RECAL_LIMIT_MS   = 600;
    localparam int RECAL_LIMIT_CYCLES = RECAL_LIMIT_MS * MS_TICK_CYCLES;
    localparam int SLIDE_STEP_MS    = 35;

    typedef enum logic [1:0] {
        RECAL_IDLE    = 2'b00,
        RECAL_ANALOG  = 2'b01,
        RECAL_DIGITAL = 2'b10
    } recal_state_type;

    // Longest press of a grouped sensor, in milliseconds, per code.
    function automatic logic [13:0] max_press_ms(input logic [3:0] code);
        logic [13:0] ms;
        ms = 14'h0230;
        case (code)
            4'h0: ms = 14'h0230;
            4'h1: ms = 14'h0348;
            4'h2: ms = 14'h0460;
            4'h3: ms = 14'h0578;
            4'h4: ms = 14'h0690;
            4'h5: ms = 14'h08C0;
            4'h6: ms = 14'h0AF0;
            4'h7: ms = 14'h0D20;
            4'h8: ms = 14'h0F50;
            4'h9: ms = 14'h1180;
            4'hA: ms = 14'h15E0;
            4'hB: ms = 14'h1A40;
            4'hC: ms = 14'h1EA0;
            4'hD: ms = 14'h22CA;
            4'hE: ms = 14'h2760;
            default: ms = 14'h2BC0;
        endcase
        return ms;
    endfunction : max_press_ms

endpackage : touch_recal_pkg

// file: hw/touch_recal_regs.sv
// Recalibration, group timing and interrupt enable register group.
// Summary of operation
// - Group timing upper nibble: max press, reset 1101b.
// - Max press code decodes 560 ms to 11200 ms.
// - Lower nibble: slide repeat, 35 ms steps, 0100b.
// - Auto recalibration ignored on sampling-disabled channels.
// - Group auto enable off stops grouped auto recalibration.
// - Bits 0-6 enable auto recalibration, reset FFh.
// - Trigger bit starts recalibration, self-clears when done.
// - Analog update first, then capture new base count.
// - Touches unreported, base invalid during recalibration.
// - New press during recalibration invalidates the attempt; a held touch does not.
// - Group trigger clears after all grouped succeed.
// - Grouped triggers for channels 8-14, bit 7 unused.
// - Bit 7 lets grouped gestures raise interrupt.
// - Bits 0-6 let channel touches raise interrupt.
// - Second enable register gates pin change interrupts.
// - Group timing applies to channels 8-14, reset D4h.
module touch_recal_regs #(
    parameter int MS_CYCLES      = touch_recal_pkg::MS_TICK_CYCLES,
    parameter int ANALOG_CYCLES  = touch_recal_pkg::RECAL_LIMIT_CYCLES / 2,
    parameter int DIGITAL_CYCLES = touch_recal_pkg::RECAL_LIMIT_CYCLES / 2
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [7:0]  reg_addr,
    input  wire logic        reg_write,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic [13:0] sample_enable,
    input  wire logic [13:0] sense_touch,
    input  wire logic [6:0]  auto_recal_request,
    input  wire logic [6:0]  touch_status,
    input  wire logic [3:0]  group_event_status,
    input  wire logic [7:0]  gpio_change_status,
    input  wire logic        slide_active,
    output logic [7:0]       reg_rdata_ff,
    output logic             irq_ff,
    output logic [13:0]      recal_busy_ff,
    output logic [13:0]      analog_update_ff,
    output logic [13:0]      base_capture_ff,
    output logic             slide_repeat_ff
);

    logic [7:0]  group_timing_ff;
    logic [7:0]  auto_recal_ff;
    logic [7:0]  trig_low_ff;
    logic [7:0]  touch_irq_ff;
    logic [7:0]  gpio_irq_ff;
    logic [6:0]  trig_grp_ff;
    logic [6:0]  grp_done_ff;
    logic [31:0] ms_cnt_ff;
    logic [13:0] press_ms_ff;
    logic        expired_ff;
    logic [9:0]  slide_ms_ff;
    logic [7:0]  nxt_group_timing;
    logic [7:0]  nxt_auto_recal;
    logic [7:0]  nxt_trig_low;
    logic [7:0]  nxt_touch_irq;
    logic [7:0]  nxt_gpio_irq;
    logic [6:0]  nxt_trig_grp;
    logic [6:0]  nxt_grp_done;
    logic [31:0] nxt_ms_cnt;
    logic [13:0] nxt_press_ms;
    logic        nxt_expired;
    logic [9:0]  nxt_slide_ms;
    logic        nxt_slide_repeat;
    logic        nxt_irq;
    logic [7:0]  nxt_rdata;
    logic        ms_tick;
    logic        group_pressed;
    logic        expire;
    logic [13:0] press_limit;
    logic [9:0]  slide_limit;
    logic [13:0] done;
    logic [13:0] start;
    logic [13:0] auto_start;
    logic [6:0]  grp_done_all;

    assign ms_tick = ms_cnt_ff == 32'(MS_CYCLES - 1);
    assign group_pressed = |(sense_touch[13:7] & sample_enable[13:7]);
    assign press_limit = touch_recal_pkg::max_press_ms(
        group_timing_ff[touch_recal_pkg::MAX_PRESS_LSB +: 4]);
    assign slide_limit = 10'(({6'h00,
        group_timing_ff[touch_recal_pkg::SLIDE_RPT_LSB +: 4]} + 10'h001)
        * touch_recal_pkg::SLIDE_STEP_MS);
    assign expire = group_pressed && ms_tick && !expired_ff
        && (press_ms_ff + 14'h0001 >= press_limit);

    // Forced recalibration of grouped sensors only when the group enable
    // is on; channels that are not sampled never start on their own.
    assign auto_start[6:0] = auto_recal_request & auto_recal_ff[6:0]
        & sample_enable[6:0];
    assign auto_start[13:7] = {7{expire & auto_recal_ff[7]}}
        & sense_touch[13:7] & sample_enable[13:7];
    assign grp_done_all = grp_done_ff | done[13:7];

    genvar ch;
    generate
        for (ch = 0; ch < 14; ch++)
        begin : g_chan
            if (ch < touch_recal_pkg::LOW_CHANNELS)
            begin : g_low
                // The trigger bit falls one cycle after done, so done masks
                // it here to keep the engine from running a second time.
                assign start[ch] = (trig_low_ff[ch] & ~done[ch])
                    | auto_start[ch];
            end
            else
            begin : g_grp
                assign start[ch] = (trig_grp_ff[ch - 7] & ~done[ch])
                    | auto_start[ch]
                    | (trig_low_ff[touch_recal_pkg::GROUP_BIT]
                       & ~grp_done_all[ch - 7]);
            end
            recal_engine #(
                .ANALOG_CYCLES  (ANALOG_CYCLES),
                .DIGITAL_CYCLES (DIGITAL_CYCLES)
            ) u_engine (
                .clock      (clock),
                .reset      (reset),
                .start      (start[ch]),
                .touch      (sense_touch[ch]),
                .busy_ff    (recal_busy_ff[ch]),
                .analog_ff  (analog_update_ff[ch]),
                .capture_ff (base_capture_ff[ch]),
                .done_ff    (done[ch])
            );
        end
    endgenerate

    always_comb
    begin
        nxt_group_timing = group_timing_ff;
        nxt_auto_recal   = auto_recal_ff;
        nxt_touch_irq    = touch_irq_ff;
        nxt_gpio_irq     = gpio_irq_ff;
        // Trigger bits fall only on success, so an abandoned attempt
        // leaves its bit standing and the engine retries.
        nxt_trig_low[6:0] = trig_low_ff[6:0] & ~done[6:0];
        nxt_trig_low[7]   = trig_low_ff[7] & ~(&grp_done_all);
        nxt_grp_done      = (trig_low_ff[7] && !(&grp_done_all))
            ? grp_done_all : 7'h00;
        nxt_trig_grp      = trig_grp_ff & ~done[13:7];
        // A software write wins over a hardware clear in the same cycle.
        if (reg_write)
        begin
            if (reg_addr == touch_recal_pkg::ADDR_GROUP_TIMING)
                nxt_group_timing = reg_wdata;
            else if (reg_addr == touch_recal_pkg::ADDR_AUTO_RECAL)
                nxt_auto_recal = reg_wdata;
            else if (reg_addr == touch_recal_pkg::ADDR_TRIG_LOW)
                nxt_trig_low = reg_wdata;
            else if (reg_addr == touch_recal_pkg::ADDR_TOUCH_IRQ)
                nxt_touch_irq = reg_wdata;
            else if (reg_addr == touch_recal_pkg::ADDR_GPIO_IRQ)
                nxt_gpio_irq = reg_wdata;
            else if (reg_addr == touch_recal_pkg::ADDR_TRIG_GROUPED)
                nxt_trig_grp = reg_wdata[6:0];
        end
    end

    always_comb
    begin
        nxt_ms_cnt = ms_tick ? 32'h0000_0000 : ms_cnt_ff + 32'h0000_0001;
        nxt_press_ms = press_ms_ff;
        nxt_expired  = expired_ff;
        if (!group_pressed)
        begin
            nxt_press_ms = 14'h0000;
            nxt_expired  = 1'b0;
        end
        else if (ms_tick && !expired_ff)
        begin
            nxt_press_ms = press_ms_ff + 14'h0001;
            nxt_expired  = expire;
        end
        nxt_slide_repeat = 1'b0;
        nxt_slide_ms     = slide_ms_ff;
        if (!slide_active)
            nxt_slide_ms = 10'h000;
        else if (ms_tick)
        begin
            if (slide_ms_ff + 10'h001 >= slide_limit)
            begin
                nxt_slide_ms     = 10'h000;
                nxt_slide_repeat = 1'b1;
            end
            else
                nxt_slide_ms = slide_ms_ff + 10'h001;
        end
    end

    always_comb
    begin
        nxt_irq = (|(touch_status & touch_irq_ff[6:0]))
            | ((|group_event_status)
               & touch_irq_ff[touch_recal_pkg::GROUP_BIT])
            | (|(gpio_change_status & gpio_irq_ff));
        if (reg_addr == touch_recal_pkg::ADDR_GROUP_TIMING)
            nxt_rdata = group_timing_ff;
        else if (reg_addr == touch_recal_pkg::ADDR_AUTO_RECAL)
            nxt_rdata = auto_recal_ff;
        else if (reg_addr == touch_recal_pkg::ADDR_TRIG_LOW)
            nxt_rdata = trig_low_ff;
        else if (reg_addr == touch_recal_pkg::ADDR_TOUCH_IRQ)
            nxt_rdata = touch_irq_ff;
        else if (reg_addr == touch_recal_pkg::ADDR_GPIO_IRQ)
            nxt_rdata = gpio_irq_ff;
        else if (reg_addr == touch_recal_pkg::ADDR_TRIG_GROUPED)
            nxt_rdata = {1'b0, trig_grp_ff};
        else
            nxt_rdata = 8'h00;
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            group_timing_ff <= touch_recal_pkg::RST_GROUP_TIMING;
            auto_recal_ff   <= touch_recal_pkg::RST_AUTO_RECAL;
            trig_low_ff     <= touch_recal_pkg::RST_TRIG_LOW;
            touch_irq_ff    <= touch_recal_pkg::RST_TOUCH_IRQ;
            gpio_irq_ff     <= touch_recal_pkg::RST_GPIO_IRQ;
            trig_grp_ff     <= touch_recal_pkg::RST_TRIG_GROUPED;
            grp_done_ff     <= 7'h00;
            ms_cnt_ff       <= 32'h0000_0000;
            press_ms_ff     <= 14'h0000;
            expired_ff      <= 1'b0;
            slide_ms_ff     <= 10'h000;
            slide_repeat_ff <= 1'b0;
            irq_ff          <= 1'b0;
            reg_rdata_ff    <= 8'h00;
        end
        else
        begin
            group_timing_ff <= nxt_group_timing;
            auto_recal_ff   <= nxt_auto_recal;
            trig_low_ff     <= nxt_trig_low;
            touch_irq_ff    <= nxt_touch_irq;
            gpio_irq_ff     <= nxt_gpio_irq;
            trig_grp_ff     <= nxt_trig_grp;
            grp_done_ff     <= nxt_grp_done;
            ms_cnt_ff       <= nxt_ms_cnt;
            press_ms_ff     <= nxt_press_ms;
            expired_ff      <= nxt_expired;
            slide_ms_ff     <= nxt_slide_ms;
            slide_repeat_ff <= nxt_slide_repeat;
            irq_ff          <= nxt_irq;
            reg_rdata_ff    <= nxt_rdata;
        end
    end

    property p_irq_follows;
        @(posedge clock) disable iff (reset)
        ##1 irq_ff == ($past(|(touch_status & touch_irq_ff[6:0]))
            || $past(|group_event_status && touch_irq_ff[7])
            || $past(|(gpio_change_status & gpio_irq_ff)));
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("Interrupt pin does not match enabled status.");

    property p_gpio_masked;
        @(posedge clock) disable iff (reset)
        (gpio_irq_ff == 8'h00 && touch_irq_ff == 8'h00) |=> !irq_ff;
    endproperty
    a_gpio_masked: assert property (p_gpio_masked)
        else $error("Interrupt raised with all enables off.");

    property p_low_trig_clears;
        @(posedge clock) disable iff (reset)
        (done[0] && !reg_write) |=> !trig_low_ff[0];
    endproperty
    a_low_trig_clears: assert property (p_low_trig_clears)
        else $error("Trigger bit not cleared after success.");

    sequence s_abandoned;
        trig_grp_ff[0] && recal_busy_ff[7] && !reg_write
            ##1 !recal_busy_ff[7] && !done[7];
    endsequence
    property p_trig_kept;
        @(posedge clock) disable iff (reset)
        s_abandoned |-> trig_grp_ff[0];
    endproperty
    a_trig_kept: assert property (p_trig_kept)
        else $error("Trigger bit lost after an abandoned attempt.");

    property p_group_trig_waits;
        @(posedge clock) disable iff (reset)
        (trig_low_ff[7] && !(&grp_done_all) && !reg_write) |=> trig_low_ff[7];
    endproperty
    a_group_trig_waits: assert property (p_group_trig_waits)
        else $error("Group trigger cleared before all grouped finished.");

    property p_no_auto_when_disabled;
        @(posedge clock) disable iff (reset)
        (!sample_enable[8] || !auto_recal_ff[7]) |-> !auto_start[8];
    endproperty
    a_no_auto_when_disabled: assert property (p_no_auto_when_disabled)
        else $error("Automatic recalibration on a disabled channel.");

    property p_unused_bit_zero;
        @(posedge clock) disable iff (reset)
        $past(reg_addr) == touch_recal_pkg::ADDR_TRIG_GROUPED
            |-> !reg_rdata_ff[7];
    endproperty
    a_unused_bit_zero: assert property (p_unused_bit_zero)
        else $error("Unused grouped trigger bit reads as one.");

    property p_expire_at_limit;
        @(posedge clock) disable iff (reset)
        expire |-> (press_ms_ff == press_limit - 14'h0001
            || press_ms_ff >= press_limit);
    endproperty
    a_expire_at_limit: assert property (p_expire_at_limit)
        else $error("Max press timeout at the wrong time.");

endmodule : touch_recal_regs
